/* File: hdl/dtps_top.sv */
// Function
// R1: The board holds the factory test pin low; other levels are not used.
// R2: Select low at reset routes the scan port to the emulation logic.
// R3: Select high at reset runs the port as a plain boundary-scan port.
// R4: The mode is latched at chip reset and never changes while running.
// R5: Boundary-scan mode supports SAMPLE, EXTEST and BYPASS.
// R6: Emulation mode answers an id request with a processor-specific code.
// R7: Three internal scan chains are selected and shifted through the port.
// R8: Halt mode injects a store-multiple and shifts the registers out.
// R9: Monitor mode passes words to a monitor program without halting.
// R10: Comm channel tx and rx flags become processor interrupt requests.
// R11: A block control prevents the emulation side from reaching the system.
// R12: A read-only 32-bit chip id gives version and configuration.
// R13: The serial port has one DMA request line per direction.
// R14: The controller samples mode and data on rising and drives out on falling.
`include "dtps_params.svh"
module dtps_top
    import dtps_pkg::*;
#(
    parameter logic [31:0] CHIP_ID = 32'h0A5A_0001, // arbitrary value
    parameter logic [31:0] CPU_ID = 32'h0C0D_0001 // arbitrary value
)(
    input wire logic mclk_i,
    input wire logic rst_i,
    input wire logic chip_reset_n_i,
    input wire logic factory_test_pin_i,
    input wire logic scan_port_select_i,
    input wire logic tck_i,
    input wire logic tms_i,
    input wire logic tdi_i,
    input wire logic ice_block_i,
    input wire logic comm_channel_tx_flag_i,
    input wire logic comm_channel_rx_flag_i,
    input wire logic [96:0] pin_in_i,
    input wire logic [31:0] cpu_reg_i,
    input wire logic cpu_reg_valid_i,
    input wire logic debug_serial_rx_i,
    input wire logic ser_tx_i,
    input wire logic ser_tx_empty_i,
    input wire logic ser_rx_full_i,
    output logic tdo_o,
    output logic tdo_oe_o,
    output logic emu_mode_o,
    output logic halt_req_o,
    output logic stm_inject_o,
    output logic [31:0] monitor_word_o,
    output logic monitor_word_valid_o,
    output logic sys_access_en_o,
    output logic comm_tx_irq_o,
    output logic comm_rx_irq_o,
    output logic [31:0] chip_id_o,
    output logic [96:0] bsr_out_o,
    output logic bsr_drive_o,
    output logic debug_serial_tx_o,
    output logic dma_tx_req_o,
    output logic dma_rx_req_o,
    output logic debug_serial_rx_o
);
    // ------------------------------------------------------------
    // Pin synchronisers
    // ------------------------------------------------------------
    logic s_tck, s_tms, s_tdi, s_sel, s_chip_reset_n;
    dtps_sync u_tck (.mclk_i(mclk_i), .rst_i(rst_i), .async_i(tck_i),
        .level_o(s_tck));
    dtps_sync u_tms (.mclk_i(mclk_i), .rst_i(rst_i), .async_i(tms_i),
        .level_o(s_tms));
    dtps_sync u_tdi (.mclk_i(mclk_i), .rst_i(rst_i), .async_i(tdi_i),
        .level_o(s_tdi));
    dtps_sync u_sel (.mclk_i(mclk_i), .rst_i(rst_i),
        .async_i(scan_port_select_i), .level_o(s_sel));
    dtps_sync u_rst (.mclk_i(mclk_i), .rst_i(rst_i),
        .async_i(chip_reset_n_i), .level_o(s_chip_reset_n));

    // ------------------------------------------------------------
    // State
    // ------------------------------------------------------------
    typedef struct packed {
        logic tck_d;
        logic chip_reset_n_d;
        logic emu;
        dtps_tap_t tap;
        logic [3:0] ir;
        logic [3:0] ir_sh;
        logic [4:0] chain;
        logic [96:0] dr;
        logic [96:0] bsr_up;
        logic bsr_drv;
        logic tdo;
        logic tdo_oe;
        logic halt;
        logic store_multiple_op;
        logic [31:0] mon;
        logic mon_v;
        logic acc;
        logic txi;
        logic rxi;
        logic ser;
        logic dtx;
        logic drx;
        logic drq;
        logic [31:0] cid;
    } dtps_top_t;
    dtps_top_t st;
    dtps_top_t next_st;
    logic rise;
    logic fall;
    logic [6:0] dr_msb;

    always_comb begin
        next_st = st;
        rise = s_tck & ~st.tck_d;
        fall = ~s_tck & st.tck_d;
        dr_msb = 7'd0;
        next_st.tck_d = s_tck;
        next_st.chip_reset_n_d = s_chip_reset_n;
        if (!s_chip_reset_n) begin
            next_st.tap = DTPS_RESET;
        end
        // The select is taken as chip reset ends: while reset is held its
        // sample may still be settling, so a glitch there cannot stick.
        if (s_chip_reset_n && !st.chip_reset_n_d) begin
            next_st.emu = ~s_sel; // see R2 see R3 see R4
        end
        // Select the serial length of the current data register.
        unique case (st.ir)
            `DTPS_IR_EXTEST, `DTPS_IR_SAMPLE: begin
                dr_msb = 7'(`DTPS_BSR_W - 1);
            end
            `DTPS_IR_SCAN_N: dr_msb = 7'(`DTPS_CHAIN_W - 1);
            `DTPS_IR_IDCODE: dr_msb = 7'(`DTPS_WORD_W - 1);
            `DTPS_IR_INTEST: begin
                dr_msb = (st.chain == `DTPS_CHAIN_DBG) ?
                    7'(`DTPS_DBG_W - 1) :
                    (st.chain == `DTPS_CHAIN_PGM) ? 7'(`DTPS_PGM_W - 1) :
                    7'(`DTPS_TST_W - 1); // see R7
            end
            default: dr_msb = 7'd0;
        endcase
        if (!st.emu && st.ir != `DTPS_IR_EXTEST &&
            st.ir != `DTPS_IR_SAMPLE && st.ir != `DTPS_IR_IDCODE) begin
            dr_msb = 7'd0; // see R5
        end
        next_st.store_multiple_op = 1'b0;
        next_st.mon_v = 1'b0;
        if (rise && s_chip_reset_n) begin // see R14
            unique case (st.tap)
                DTPS_RESET: next_st.tap = s_tms ? DTPS_RESET : DTPS_IDLE;
                DTPS_IDLE: next_st.tap = s_tms ? DTPS_SEL_DR : DTPS_IDLE;
                DTPS_SEL_DR: next_st.tap = s_tms ? DTPS_SEL_IR : DTPS_CAP_DR;
                DTPS_CAP_DR: next_st.tap = s_tms ? DTPS_EX1_DR : DTPS_SH_DR;
                DTPS_SH_DR: next_st.tap = s_tms ? DTPS_EX1_DR : DTPS_SH_DR;
                DTPS_EX1_DR: next_st.tap = s_tms ? DTPS_UP_DR : DTPS_PA_DR;
                DTPS_PA_DR: next_st.tap = s_tms ? DTPS_EX2_DR : DTPS_PA_DR;
                DTPS_EX2_DR: next_st.tap = s_tms ? DTPS_UP_DR : DTPS_SH_DR;
                DTPS_UP_DR: next_st.tap = s_tms ? DTPS_SEL_DR : DTPS_IDLE;
                DTPS_SEL_IR: next_st.tap = s_tms ? DTPS_RESET : DTPS_CAP_IR;
                DTPS_CAP_IR: next_st.tap = s_tms ? DTPS_EX1_IR : DTPS_SH_IR;
                DTPS_SH_IR: next_st.tap = s_tms ? DTPS_EX1_IR : DTPS_SH_IR;
                DTPS_EX1_IR: next_st.tap = s_tms ? DTPS_UP_IR : DTPS_PA_IR;
                DTPS_PA_IR: next_st.tap = s_tms ? DTPS_EX2_IR : DTPS_PA_IR;
                DTPS_EX2_IR: next_st.tap = s_tms ? DTPS_UP_IR : DTPS_SH_IR;
                DTPS_UP_IR: next_st.tap = s_tms ? DTPS_SEL_DR : DTPS_IDLE;
            endcase
            unique case (st.tap)
                DTPS_RESET: begin
                    next_st.ir = `DTPS_IR_IDCODE;
                    next_st.bsr_drv = 1'b0;
                end
                DTPS_CAP_IR: next_st.ir_sh = `DTPS_IR_CAPTURE;
                DTPS_SH_IR: next_st.ir_sh = {s_tdi, st.ir_sh[3:1]};
                DTPS_UP_IR: begin
                    next_st.ir = st.ir_sh;
                    next_st.bsr_drv = ~st.emu &&
                        st.ir_sh == `DTPS_IR_EXTEST;
                end
                DTPS_CAP_DR: begin
                    next_st.dr = '0;
                    if (st.ir == `DTPS_IR_IDCODE) begin
                        next_st.dr[31:0] = st.emu ? CPU_ID : CHIP_ID; // see R6
                    end else if (st.ir == `DTPS_IR_EXTEST ||
                        st.ir == `DTPS_IR_SAMPLE) begin
                        next_st.dr = pin_in_i;
                    end else if (st.ir == `DTPS_IR_INTEST && st.emu &&
                        cpu_reg_valid_i) begin
                        next_st.dr[31:0] = cpu_reg_i; // see R8
                    end
                end
                DTPS_SH_DR: begin
                    next_st.dr = {1'b0, st.dr[96:1]};
                    next_st.dr[dr_msb] = s_tdi;
                end
                DTPS_UP_DR: begin
                    if (st.ir == `DTPS_IR_EXTEST && !st.emu) begin
                        next_st.bsr_up = st.dr;
                    end
                    if (st.emu && st.ir == `DTPS_IR_SCAN_N) begin
                        next_st.chain = st.dr[`DTPS_CHAIN_W-1:0]; // see R7
                    end
                    if (st.emu && st.ir == `DTPS_IR_INTEST &&
                        st.chain == `DTPS_CHAIN_DBG) begin
                        // Bit 32 requests halt; word is the pipe op.
                        next_st.halt = st.dr[`DTPS_WORD_W];
                        next_st.store_multiple_op = st.dr[`DTPS_WORD_W] & st.halt; // see R8
                        next_st.mon = st.dr[`DTPS_WORD_W-1:0];
                        next_st.mon_v = ~st.dr[`DTPS_WORD_W]; // see R9
                    end
                end
                default: begin
                end
            endcase
        end
        if (fall) begin // see R14
            next_st.tdo_oe = st.tap == DTPS_SH_DR || st.tap == DTPS_SH_IR;
            next_st.tdo = (st.tap == DTPS_SH_IR) ? st.ir_sh[0] : st.dr[0];
        end
        // Blocking keeps a debugger from touching memory while the chip
        // stays runnable; the scan port itself keeps working.
        next_st.acc = st.emu & ~ice_block_i; // see R11
        next_st.txi = comm_channel_tx_flag_i; // see R10
        next_st.rxi = comm_channel_rx_flag_i; // see R10
        next_st.ser = ser_tx_empty_i;
        next_st.dtx = ser_tx_i;
        next_st.drx = debug_serial_rx_i;
        next_st.drq = ser_rx_full_i; // see R13
        next_st.cid = CHIP_ID; // see R12
        if (rst_i) begin
            next_st = '0;
            next_st.tap = DTPS_RESET;
            next_st.ir = `DTPS_IR_IDCODE;
            next_st.dtx = 1'b1;
            next_st.drx = 1'b1;
        end
    end

    always_ff @(posedge mclk_i) begin
        st <= next_st;
    end

    // ------------------------------------------------------------
    // Outputs
    // ------------------------------------------------------------
    assign tdo_o = st.tdo;
    assign tdo_oe_o = st.tdo_oe;
    assign emu_mode_o = st.emu;
    assign halt_req_o = st.halt;
    assign stm_inject_o = st.store_multiple_op;
    assign monitor_word_o = st.mon;
    assign monitor_word_valid_o = st.mon_v;
    assign sys_access_en_o = st.acc;
    assign comm_tx_irq_o = st.txi;
    assign comm_rx_irq_o = st.rxi;
    assign chip_id_o = st.cid; // see R12
    assign bsr_out_o = st.bsr_up;
    assign bsr_drive_o = st.bsr_drv;
    assign debug_serial_tx_o = st.dtx;
    assign dma_tx_req_o = st.ser; // see R13
    assign dma_rx_req_o = st.drq;
    assign debug_serial_rx_o = st.drx;
    // The factory test pin is only observed by test logic outside.
    logic unused_tst;
    assign unused_tst = factory_test_pin_i; // see R1
endmodule : dtps_top

/* File: shared/dtps_params.svh */
`ifndef DTPS_PARAMS_SVH
`define DTPS_PARAMS_SVH
`define DTPS_IR_W 4
`define DTPS_IR_EXTEST 4'h0
`define DTPS_IR_SAMPLE 4'h1
`define DTPS_IR_SCAN_N 4'h2
`define DTPS_IR_INTEST 4'hC
`define DTPS_IR_IDCODE 4'hE
`define DTPS_IR_BYPASS 4'hF
`define DTPS_IR_CAPTURE 4'h1
`define DTPS_BSR_W 97
`define DTPS_CHAIN_W 5
`define DTPS_CHAIN_DBG 5'h01
`define DTPS_CHAIN_PGM 5'h02
`define DTPS_CHAIN_TST 5'h00
`define DTPS_DBG_W 33
`define DTPS_PGM_W 38
`define DTPS_TST_W 32
`define DTPS_WORD_W 32
`define DTPS_ZERO32 32'h0000_0000
`endif

/* File: shared/dtps_pkg.sv */
package dtps_pkg;
    typedef enum logic [3:0] {
        DTPS_RESET = 4'b0000,
        DTPS_IDLE = 4'b0001,
        DTPS_SEL_DR = 4'b0010,
        DTPS_CAP_DR = 4'b0011,
        DTPS_SH_DR = 4'b0100,
        DTPS_EX1_DR = 4'b0101,
        DTPS_PA_DR = 4'b0110,
        DTPS_EX2_DR = 4'b0111,
        DTPS_UP_DR = 4'b1000,
        DTPS_SEL_IR = 4'b1001,
        DTPS_CAP_IR = 4'b1010,
        DTPS_SH_IR = 4'b1011,
        DTPS_EX1_IR = 4'b1100,
        DTPS_PA_IR = 4'b1101,
        DTPS_EX2_IR = 4'b1110,
        DTPS_UP_IR = 4'b1111
    } dtps_tap_t;
endpackage : dtps_pkg

/* File: hdl/dtps_sync.sv */
`include "dtps_params.svh"
module dtps_sync
    import dtps_pkg::*;
(
    input wire logic mclk_i,
    input wire logic rst_i,
    input wire logic async_i,
    output logic level_o
);
    typedef struct packed {
        logic [2:0] pipe;
        logic level;
    } dtps_sync_t;
    dtps_sync_t st;
    dtps_sync_t next_st;
    always_comb begin
        next_st = st;
        next_st.pipe = {st.pipe[1:0], async_i};
        // Change accepted only when stages two and three agree.
        if (st.pipe[2] == st.pipe[1]) begin
            next_st.level = st.pipe[2];
        end
        if (rst_i) begin
            next_st = '0;
        end
    end
    always_ff @(posedge mclk_i) begin
        st <= next_st;
    end
    assign level_o = st.level;
endmodule : dtps_sync

/* File: test/dtps_props.sv */
module dtps_props
    import dtps_pkg::*;
#(
    parameter logic [31:0] CHIP_ID = 32'h0A5A_0001
)(
    input wire logic mclk_i,
    input wire logic rst_i,
    input wire logic chip_reset_n_i,
    input wire logic tck_i,
    input wire logic ice_block_i,
    input wire logic comm_channel_tx_flag_i,
    input wire logic comm_channel_rx_flag_i,
    input wire logic ser_tx_empty_i,
    input wire logic ser_rx_full_i,
    input wire logic tdo_o,
    input wire logic tdo_oe_o,
    input wire logic emu_mode_o,
    input wire logic halt_req_o,
    input wire logic stm_inject_o,
    input wire logic monitor_word_valid_o,
    input wire logic sys_access_en_o,
    input wire logic comm_tx_irq_o,
    input wire logic comm_rx_irq_o,
    input wire logic [31:0] chip_id_o,
    input wire logic [96:0] bsr_out_o,
    input wire logic dma_tx_req_o,
    input wire logic dma_rx_req_o
);
    timeunit 1ns;
    timeprecision 100ps;
    // ----------------------------------------------------------------
    // Port checks.
    // ----------------------------------------------------------------
    default clocking cb @(posedge mclk_i);
    endclocking
    default disable iff (rst_i);
    a_mode_held: assert property (
        chip_reset_n_i [*8] |=> $stable(emu_mode_o))
        else $error("mode changed while running");
    // The test clock passes a 3-stage synchroniser, so a lag of 3 to 5.
    a_tdo_on_fall: assert property (
        $changed(tdo_o) && chip_reset_n_i |->
        !$past(tck_i, 3) || !$past(tck_i, 4) || !$past(tck_i, 5))
        else $error("tdo moved without a falling test clock");
    a_oe_on_fall: assert property (
        $rose(tdo_oe_o) |->
        !$past(tck_i, 3) || !$past(tck_i, 4) || !$past(tck_i, 5))
        else $error("tdo enable rose without a falling edge");
    a_bsr_scan_only: assert property (
        chip_reset_n_i [*6] ##0 $changed(bsr_out_o) |-> !emu_mode_o)
        else $error("pin drive changed in emulation mode");
    a_inject_pulse: assert property (
        stm_inject_o |-> (halt_req_o && emu_mode_o) ##1 !stm_inject_o)
        else $error("inject pulse not single or not halted");
    a_monitor_pulse: assert property (
        monitor_word_valid_o |-> emu_mode_o ##1 !monitor_word_valid_o)
        else $error("monitor word strobe wrong");
    a_access_cause: assert property (
        sys_access_en_o |-> $past(emu_mode_o) && !$past(ice_block_i))
        else $error("system access while blocked");
    a_access_grant: assert property (
        (emu_mode_o && !ice_block_i) [*2] |-> sys_access_en_o)
        else $error("system access not granted");
    a_tx_irq_rise: assert property (
        $rose(comm_channel_tx_flag_i) |=> comm_tx_irq_o)
        else $error("tx flag gave no request");
    a_rx_irq_rise: assert property (
        $rose(comm_channel_rx_flag_i) |=> comm_rx_irq_o)
        else $error("rx flag gave no request");
    a_dma_follow: assert property (
        dma_tx_req_o == $past(ser_tx_empty_i) &&
        dma_rx_req_o == $past(ser_rx_full_i))
        else $error("dma request does not follow serial status");
    a_chip_id: assert property (
        !$past(rst_i) |-> chip_id_o == CHIP_ID)
        else $error("chip id differs");
    c_inject: cover property (stm_inject_o);
    c_monitor: cover property (monitor_word_valid_o);
    c_bsr: cover property ($changed(bsr_out_o));
endmodule : dtps_props

/* File: test/dtps_dbg_model.sv */
module dtps_dbg_model (
    output logic tck_o,
    output logic tms_o,
    output logic tdi_o,
    input wire logic tdo_i
);
    timeunit 1ns;
    timeprecision 100ps;
    // ----------------------------------------------------------------
    // External debugger: one 64 ns test clock period per bit.
    // ----------------------------------------------------------------
    initial begin
        tck_o = 1'b1;
        tms_o = 1'b1;
        tdi_o = 1'b0;
    end
    // Tdo is read late in the high phase because it lags the fall.
    task automatic bit_x(input logic m, input logic d, output logic q);
        tck_o = 1'b0;
        tms_o = m;
        tdi_o = d;
        #32 tck_o = 1'b1;
        #32 q = tdo_i;
    endtask : bit_x
endmodule : dtps_dbg_model

/* File: test/tb_top.sv */
`include "dtps_params.svh"
module tb_top
    import dtps_pkg::*;
;
    timeunit 1ns;
    timeprecision 100ps;
    // ----------------------------------------------------------------
    // Bench.
    // ----------------------------------------------------------------
    localparam logic [31:0] CID = 32'h0A5A_00C3; // Arbitrary value.
    localparam logic [31:0] PID = 32'h0C0D_0044; // Arbitrary value.
    logic mclk_i = 1'b0;
    logic rst_i = 1'b1;
    logic crst_n = 1'b1, sel = 1'b1, blk = 1'b0, creg_v = 1'b0;
    logic [5:0] side = 6'h00;
    logic [96:0] pins = '0;
    logic [31:0] creg = 32'h0000_0000;
    logic tck, tms, tdi, tdo, tdo_oe, emu, halt, inj, mon_v, acc, bdrv;
    logic [31:0] mon_w, cid;
    logic [96:0] bsr;
    wire [5:0] side_o;
    int error_cnt = 0;
    int samples_checked = 0;
    int inj_n = 0, mon_n = 0;
    dtps_top #(.CHIP_ID(CID), .CPU_ID(PID)) dut_u (
        .mclk_i, .rst_i, .chip_reset_n_i(crst_n),
        .factory_test_pin_i(1'b0),
        .scan_port_select_i(sel), .tck_i(tck), .tms_i(tms), .tdi_i(tdi),
        .ice_block_i(blk), .comm_channel_tx_flag_i(side[5]),
        .comm_channel_rx_flag_i(side[4]), .pin_in_i(pins), .cpu_reg_i(creg),
        .cpu_reg_valid_i(creg_v), .debug_serial_rx_i(side[1]),
        .ser_tx_i(side[0]), .ser_tx_empty_i(side[3]), .ser_rx_full_i(side[2]),
        .tdo_o(tdo), .tdo_oe_o(tdo_oe), .emu_mode_o(emu), .halt_req_o(halt),
        .stm_inject_o(inj), .monitor_word_o(mon_w),
        .monitor_word_valid_o(mon_v), .sys_access_en_o(acc),
        .comm_tx_irq_o(side_o[5]), .comm_rx_irq_o(side_o[4]), .chip_id_o(cid),
        .bsr_out_o(bsr), .bsr_drive_o(bdrv), .debug_serial_tx_o(side_o[0]),
        .dma_tx_req_o(side_o[3]), .dma_rx_req_o(side_o[2]),
        .debug_serial_rx_o(side_o[1])
    );
    dtps_dbg_model dbg_u (.tck_o(tck), .tms_o(tms), .tdi_o(tdi), .tdo_i(tdo));
    always #4 mclk_i = ~mclk_i;
    always @(posedge mclk_i) begin
        if (inj === 1'b1) inj_n++;
        if (mon_v === 1'b1) mon_n++;
    end
    task automatic chk(string n, logic [127:0] e, logic [127:0] g);
        samples_checked++;
        if (g !== e) begin
            error_cnt++;
            $display("MISMATCH %s expected %h seen %h", n, e, g);
        end
    endtask : chk
    task automatic end_sim;
        $display("Checks %0d errors %0d", samples_checked, error_cnt);
        if (error_cnt == 0 && samples_checked > 0) begin
            $display("Simulation passed");
        end else begin
            $display("Simulation failed");
        end
        $finish;
    endtask : end_sim
    task automatic chip_rst(input logic s);
        logic b;
        @(posedge mclk_i) #1 sel = s;
        crst_n = 1'b0;
        repeat (8) @(posedge mclk_i);
        #1 crst_n = 1'b1;
        repeat (8) @(posedge mclk_i);
        #1;
        repeat (6) dbg_u.bit_x(1'b1, 1'b0, b);
        dbg_u.bit_x(1'b0, 1'b0, b);
    endtask : chip_rst
    task automatic ir(input logic [3:0] code, output logic [3:0] cap);
        logic [9:0] m = 10'b01_1000_0011;
        logic q;
        for (int i = 0; i < 10; i++) begin
            dbg_u.bit_x(m[i], (i > 3 && i < 8) ? code[(i+4)%4] : 1'b0, q);
            if (i > 3 && i < 8) cap[i%4] = q;
        end
    endtask : ir
    task automatic dr(input logic [127:0] d, input int n,
                      output logic [127:0] q);
        logic b;
        q = '0;
        dbg_u.bit_x(1'b1, 1'b0, b);
        repeat (2) dbg_u.bit_x(1'b0, 1'b0, b);
        for (int i = 0; i < n; i++) begin
            dbg_u.bit_x(i == n - 1, d[i], b);
            q[i] = b;
        end
        dbg_u.bit_x(1'b1, 1'b0, b);
        repeat (2) dbg_u.bit_x(1'b0, 1'b0, b);
    endtask : dr
    task automatic sc_side;
        logic [5:0] pat [4] = '{6'h2A, 6'h15, 6'h3F, 6'h00};
        foreach (pat[k]) begin
            @(posedge mclk_i) #1 side = pat[k];
            repeat (2) @(posedge mclk_i);
            #1 chk("side", pat[k], side_o);
        end
        chk("chip id", CID, cid);
    endtask : sc_side
    task automatic sc_emu;
        logic [127:0] q;
        logic [3:0] c;
        chip_rst(1'b0);
        chk("emu", 1, emu);
        @(posedge mclk_i) #1 sel = 1'b1;
        repeat (20) @(posedge mclk_i);
        #1 chk("emu held", 1, emu);
        ir(`DTPS_IR_IDCODE, c);
        dr(0, 32, q);
        chk("cpu id", PID, q);
        ir(`DTPS_IR_SCAN_N, c);
        dr(`DTPS_CHAIN_DBG, `DTPS_CHAIN_W, q);
        ir(`DTPS_IR_INTEST, c);
        dr({1'b0, 32'h1357_9BDF}, 33, q);
        chk("mon word", 32'h1357_9BDF, mon_w);
        chk("mon pulses", 1, mon_n);
        @(posedge mclk_i) #1 creg = 32'hC0DE_5A17;
        creg_v = 1'b1;
        dr({1'b1, 32'h0000_0000}, 33, q);
        chk("halt", 1, halt);
        dr({1'b1, 32'h0000_0000}, 33, q);
        chk("reg out", 32'hC0DE_5A17, q[31:0]);
        chk("inject", 1, inj_n);
        @(posedge mclk_i) #1 blk = 1'b1;
        repeat (3) @(posedge mclk_i);
        #1 chk("blocked", 0, acc);
        blk = 1'b0;
        repeat (3) @(posedge mclk_i);
        #1 chk("access", 1, acc);
    endtask : sc_emu
    task automatic sc_bscan;
        logic [127:0] q;
        logic [3:0] c;
        logic [96:0] p = {1'b1, 32'hA5C3_0F96, 64'h0123_4567_89AB_CDEF};
        logic [96:0] np = ~p;
        logic [3:0] codes [3] = '{`DTPS_IR_BYPASS, 4'h5, 4'h7};
        chip_rst(1'b1);
        chk("emu", 0, emu);
        ir(`DTPS_IR_SAMPLE, c);
        chk("ir cap", 4'h1, c);
        @(posedge mclk_i) #1 pins = p;
        dr(0, 97, q);
        chk("sample", p, q);
        ir(`DTPS_IR_EXTEST, c);
        dr(np, 97, q);
        chk("extest cap", p, q);
        repeat (8) @(posedge mclk_i);
        #1 chk("bsr", np, bsr);
        chk("drive", 1, bdrv);
        foreach (codes[k]) begin
            ir(codes[k], c);
            dr(128'h00A5, 9, q);
            chk("bypass", 128'h014A, q);
        end
    endtask : sc_bscan
    initial begin
        repeat (10) @(posedge mclk_i);
        #1 rst_i = 1'b0;
        sc_side;
        sc_emu;
        sc_bscan;
        end_sim;
    end
    initial begin
        #200_000;
        error_cnt++;
        end_sim;
    end
endmodule : tb_top
bind dtps_top dtps_props #(.CHIP_ID(CHIP_ID)) props_u (
    .mclk_i, .rst_i, .chip_reset_n_i, .tck_i, .ice_block_i,
    .comm_channel_tx_flag_i, .comm_channel_rx_flag_i, .ser_tx_empty_i,
    .ser_rx_full_i, .tdo_o, .tdo_oe_o, .emu_mode_o, .halt_req_o,
    .stm_inject_o, .monitor_word_valid_o, .sys_access_en_o, .comm_tx_irq_o,
    .comm_rx_irq_o, .chip_id_o, .bsr_out_o, .dma_tx_req_o,
    .dma_rx_req_o
);
